// [design/lccr_top.v]
// Local configuration and control register with ROM bit-bang, lane select,
// power-down filter and PME wake gating.
// Assumes a decoded register strobe from the PCI target on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "lccr_consts.vh"

// How it works
// - Register decoded at offset 0x00 from either function, I/O or memory window.
// - I/O accesses byte-wide only; memory accesses byte, word or dword.
// - Bits 1:0 read live mode strap pins, read-only.
// - Bit 2 gates buffered UART clock onto pin; else pin low; resets zero.
// - Bits 4:3 pick byte lane for 8-bit memory accesses; reset 00.
// - Memory accesses dword aligned; 8-bit regions use only chosen lane.
// - In 32-bit local bus mode the lane select is ignored on writes; reads are still masked to the chosen lane.
// - Bits 6:5 pick power-down filter: off, 4 s, 129 s, 518 s.
// - After filter time with request still present, power-down interrupt may fire.
// - Bit 7 lets multi-purpose pin 2 set function-1 PME status.
// - Bit 24 drives ROM serial clock; software toggles it per edge.
// - Bit 25 drives ROM select high when one, low when zero.
// - Bit 26 drives ROM serial data out pin.
// - Bit 27 reads current level of ROM serial data in pin.
// - Bit 28 read-only, one when a valid ROM program was found.
// - Writing one to bit 29 starts reload; clears when ROM read finishes.
// - Pin 2 wake polarity comes from pin config bit 4.
module lccr_top #(
  parameter CLK_HZ = `LCCR_CLK_HZ,
  parameter [39:0] PD_CYC_1 = `LCCR_PD_T1_S * CLK_HZ,
  parameter [39:0] PD_CYC_2 = `LCCR_PD_T2_S * CLK_HZ,
  parameter [39:0] PD_CYC_3 = `LCCR_PD_T3_S * CLK_HZ
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Register access from the PCI target
  input wire reg_sel_i,
  input wire reg_io_space_i,
  input wire [7:0] reg_offset_i,
  input wire reg_wr_i,
  input wire [3:0] reg_be_i,
  input wire [31:0] reg_wdata_i,
  output reg [31:0] reg_rdata_o,
  output wire reg_err_o,
  // Pin configuration bit from the multi-purpose I/O register
  input wire multi_purpose_pin_config_pol_i,
  // Straps and pins
  input wire [1:0] mode_pin_i,
  input wire uart_clk_i,
  output wire uart_clk_out_o,
  input wire multi_purpose_pin_2_i,
  output wire rom_serial_clock_pin_o,
  output wire rom_select_pin_o,
  output wire rom_data_out_pin_o,
  input wire rom_data_in_pin_i,
  // ROM loader handshake
  input wire rom_valid_i,
  input wire reload_done_i,
  output wire reload_req_o,
  // Data path lane steering
  input wire bus32_mode_i,
  input wire [31:0] mem_wdata_i,
  output wire [7:0] narrow_wdata_o,
  input wire [7:0] narrow_rdata_i,
  output wire [31:0] mem_rdata_o,
  // Power management
  input wire pd_request_i,
  output reg pd_irq_o,
  output reg pme_set_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg clken_q;
  reg [1:0] lane_q;
  reg [1:0] pdsel_q;
  reg pme_en_q;
  reg rclk_q;
  reg rsel_q;
  reg rdo_q;
  reg reload_q;
  reg [39:0] pd_cnt_q;
  reg pd_arm_q;
  reg wake_prev_q;
  wire [1:0] mode_s;
  wire rdi_s;
  wire wake_s;
  wire wake_lvl;
  wire hit;
  wire io_ok;
  wire wr_en;
  wire [3:0] be_eff;
  wire [31:0] ctrl_word;
  reg [39:0] pd_limit;

  // Lane decode used on the read path only
  function [31:0] lane_mask;
    input [1:0] lane;
    begin
      lane_mask = 32'h000000FF << {lane, 3'b000};
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  lccr_sync2 #(
    .W(4)
  ) u_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i({mode_pin_i, rom_data_in_pin_i, multi_purpose_pin_2_i}),
    .sync_o({mode_s, rdi_s, wake_s})
  );

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  assign hit = reg_sel_i && (reg_offset_i == `LCCR_OFF_CONTROL);
  // I/O window only takes single-byte accesses; wider ones are refused
  assign io_ok = (reg_be_i == 4'h1) || (reg_be_i == 4'h2) ||
                 (reg_be_i == 4'h4) || (reg_be_i == 4'h8);
  assign reg_err_o = hit && reg_io_space_i && !io_ok;
  assign be_eff = reg_err_o ? 4'h0 : reg_be_i;
  assign wr_en = hit && reg_wr_i;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      clken_q <= 1'b0;
      lane_q <= 2'b00;
      pdsel_q <= 2'b00;
      pme_en_q <= 1'b0;
      rclk_q <= 1'b0;
      rsel_q <= 1'b0;
      rdo_q <= 1'b0;
      reload_q <= 1'b0;
    end
    else
    begin
      if (wr_en && be_eff[0])
      begin
        clken_q <= reg_wdata_i[`LCCR_B_CLKEN];
        lane_q <= reg_wdata_i[`LCCR_B_LANE_HI:`LCCR_B_LANE_LO];
        pdsel_q <= reg_wdata_i[`LCCR_B_PD_HI:`LCCR_B_PD_LO];
        pme_en_q <= reg_wdata_i[`LCCR_B_PME_EN];
      end
      if (wr_en && be_eff[3])
      begin
        rclk_q <= reg_wdata_i[`LCCR_B_RCLK];
        rsel_q <= reg_wdata_i[`LCCR_B_RSEL];
        rdo_q <= reg_wdata_i[`LCCR_B_RDO];
      end
      // A fresh write of one wins over a done in the same cycle
      if (wr_en && be_eff[3] && reg_wdata_i[`LCCR_B_RELOAD])
        reload_q <= 1'b1;
      else if (reload_done_i)
        reload_q <= 1'b0;
    end
  end

  assign reload_req_o = reload_q;

  // Pins come straight from flops so every write shows at once
  assign rom_serial_clock_pin_o = rclk_q;
  assign rom_select_pin_o = rsel_q;
  assign rom_data_out_pin_o = rdo_q;

  // Gated clock pin: plain AND, a glitch on enable change is tolerated
  assign uart_clk_out_o = uart_clk_i & clken_q;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  assign ctrl_word = {2'b00, reload_q, rom_valid_i, rdi_s, rdo_q, rsel_q, rclk_q,
                      16'h0000,
                      pme_en_q, pdsel_q, lane_q, clken_q, mode_s};

  always @(posedge clock_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 32'h00000000;
    else if (hit && !reg_wr_i)
      reg_rdata_o <= ctrl_word;
    else
      reg_rdata_o <= 32'h00000000;
  end

  // ----------------------------------------
  // Byte lane steering
  // ----------------------------------------
  assign narrow_wdata_o = bus32_mode_i ? mem_wdata_i[7:0] :
                          mem_wdata_i[{lane_q, 3'b000} +: 8];
  assign mem_rdata_o = {4{narrow_rdata_i}} & lane_mask(lane_q);

  // ----------------------------------------
  // Power-down filter
  // ----------------------------------------
  always @*
  begin
    case (pdsel_q)
      2'b01: pd_limit = PD_CYC_1;
      2'b10: pd_limit = PD_CYC_2;
      2'b11: pd_limit = PD_CYC_3;
      default: pd_limit = 40'h0000000000;
    endcase
  end

  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      pd_cnt_q <= 40'h0000000000;
      pd_arm_q <= 1'b0;
      pd_irq_o <= 1'b0;
    end
    else if (pdsel_q == 2'b00 || !pd_request_i)
    begin
      pd_cnt_q <= 40'h0000000000;
      pd_arm_q <= 1'b0;
      pd_irq_o <= 1'b0;
    end
    else if (!pd_arm_q)
    begin
      if (pd_cnt_q + 40'h0000000001 >= pd_limit)
      begin
        pd_arm_q <= 1'b1;
        pd_irq_o <= 1'b1;
      end
      else
        pd_cnt_q <= pd_cnt_q + 40'h0000000001;
    end
  end

  // ----------------------------------------
  // PME wake input
  // ----------------------------------------
  assign wake_lvl = wake_s ^ multi_purpose_pin_config_pol_i;

  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      wake_prev_q <= 1'b0;
      pme_set_o <= 1'b0;
    end
    else
    begin
      wake_prev_q <= wake_lvl;
      pme_set_o <= pme_en_q && wake_lvl && !wake_prev_q;
    end
  end

endmodule // lccr_top

`default_nettype wire

// [design/lccr_consts.vh]
// Constants for the local configuration and control register block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef LCCR_CONSTS_VH
`define LCCR_CONSTS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define LCCR_OFF_CONTROL 8'h00
`define LCCR_OFF_MPCFG 8'h04

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LCCR_B_MODE_LO 0
`define LCCR_B_MODE_HI 1
`define LCCR_B_CLKEN 2
`define LCCR_B_LANE_LO 3
`define LCCR_B_LANE_HI 4
`define LCCR_B_PD_LO 5
`define LCCR_B_PD_HI 6
`define LCCR_B_PME_EN 7
`define LCCR_B_RCLK 24
`define LCCR_B_RSEL 25
`define LCCR_B_RDO 26
`define LCCR_B_RDI 27
`define LCCR_B_VALID 28
`define LCCR_B_RELOAD 29
`define LCCR_B_MPCFG_POL 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCCR_RST_CTRL 8'h00
`define LCCR_RST_ROM 3'h0

// ----------------------------------------
// Filter times
// ----------------------------------------
`define LCCR_CLK_HZ 10000000
`define LCCR_PD_T1_S 4
`define LCCR_PD_T2_S 129
`define LCCR_PD_T3_S 518

`endif

// [design/lccr_sync2.v]
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes the pins change slowly relative to clock_i.
`timescale 1ns/100ps
`default_nettype none

module lccr_sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Data
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // lccr_sync2

`default_nettype wire

// [tb/lccr_properties.sv]
// Port assertions for lccr_top.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/100ps
`default_nettype none
module lccr_properties (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic reg_sel_i,
  input wire logic reg_io_space_i,
  input wire logic [7:0] reg_offset_i,
  input wire logic reg_wr_i,
  input wire logic [3:0] reg_be_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_err_o,
  input wire logic uart_clk_out_o,
  input wire logic rom_serial_clock_pin_o,
  input wire logic rom_select_pin_o,
  input wire logic rom_data_out_pin_o,
  input wire logic reload_done_i,
  input wire logic reload_req_o
);
  wire hit = reg_sel_i && reg_wr_i && reg_offset_i == 8'h00 && !reg_err_o;
  wire top = hit && reg_be_i[3];
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_clk_gate: assert property (hit && reg_be_i[0] && !reg_wdata_i[2] |=> !uart_clk_out_o) else $error("clk on");
  a_sel_pin: assert property (top |=> rom_select_pin_o == $past(reg_wdata_i[25])) else $error("select");
  a_sck_pin: assert property (top |=> rom_serial_clock_pin_o == $past(reg_wdata_i[24])) else $error("sck");
  a_dout_pin: assert property (top |=> rom_data_out_pin_o == $past(reg_wdata_i[26])) else $error("dout");
  a_pins_hold: assert property (!top |=> $stable({rom_serial_clock_pin_o, rom_select_pin_o})) else $error("pin");
  a_rsv_zero: assert property (reg_sel_i |=> reg_rdata_o[23:8] == 16'h0000 && reg_rdata_o[31:30] == 2'h0) else $error("rsv");
  a_io_refuse: assert property (reg_sel_i && reg_io_space_i && reg_offset_i == 8'h00 && !$onehot(reg_be_i) |-> reg_err_o) else $error("io");
  a_reload_set: assert property (top && reg_wdata_i[29] |=> reload_req_o) else $error("reload set");
  a_reload_clr: assert property (reload_done_i && !(top && reg_wdata_i[29]) |=> !reload_req_o) else $error("reload clr");
endmodule // lccr_properties
bind lccr_top lccr_properties u_props (.*);
`default_nettype wire

// [tb/lccr_rom_model.sv]
// Serial ROM stand-in shifting a fixed pattern out on its data line.
// Assumes the block bit-bangs clock and select from its register.
`timescale 1ns/100ps
`default_nettype none
module lccr_rom_model #(
  parameter [7:0] PAT = 8'hB4
) (
  input wire logic sck_i,
  input wire logic sel_i,
  output logic sdo_o
);
  logic [2:0] idx_q = 3'h0;
  // Advances on each rising serial clock while selected
  always @(posedge sck_i or negedge sel_i)
    if (!sel_i)
      idx_q <= 3'h0;
    else
      idx_q <= idx_q + 3'h1;
  // Deselected line shows the inverse, never a held value
  assign sdo_o = sel_i ? PAT[~idx_q] : ~PAT[~idx_q];
endmodule // lccr_rom_model
`default_nettype wire

// [tb/lccr_top_tb.sv]
// Self-checking bench for the local config control register.
// Assumes lccr_top, lccr_rom_model and lccr_properties compiled.
`timescale 1ns/100ps
`default_nettype none
module lccr_top_tb;
  localparam [7:0] PAT = 8'hB4;
  logic clock_i = 1'h0, rst_n_i = 1'h0, sel = 1'h0, io = 1'h0, wr = 1'h0, uclk = 1'h0, mp2 = 1'h0;
  logic done = 1'h0, b32 = 1'h0, pdr = 1'h0, er, ers, uco, sck, cs, dout, rdi, req, irq, pme;
  logic pol = 1'h0, vld = 1'h1;
  logic [1:0] mode = 2'h2;
  logic [3:0] be = 4'h0;
  logic [7:0] off = 8'h00, nwd;
  logic [31:0] wd = 32'h0, rd, rdo, mrd;
  int error_cnt = 0, check_count = 0;
  always #50 clock_i = ~clock_i;
  lccr_top #(.PD_CYC_1(40'hA), .PD_CYC_2(40'h14), .PD_CYC_3(40'h1E)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_sel_i(sel), .reg_io_space_i(io), .reg_offset_i(off),
    .reg_wr_i(wr), .reg_be_i(be), .reg_wdata_i(wd), .reg_rdata_o(rdo), .reg_err_o(er),
    .multi_purpose_pin_config_pol_i(pol), .mode_pin_i(mode), .uart_clk_i(uclk), .uart_clk_out_o(uco),
    .multi_purpose_pin_2_i(mp2), .rom_serial_clock_pin_o(sck), .rom_select_pin_o(cs),
    .rom_data_out_pin_o(dout), .rom_data_in_pin_i(rdi), .rom_valid_i(vld), .reload_done_i(done),
    .reload_req_o(req), .bus32_mode_i(b32), .mem_wdata_i(32'h44332211), .narrow_wdata_o(nwd),
    .narrow_rdata_i(8'hA5), .mem_rdata_o(mrd), .pd_request_i(pdr), .pd_irq_o(irq), .pme_set_o(pme));
  lccr_rom_model #(.PAT(PAT)) rom (.sck_i(sck), .sel_i(cs), .sdo_o(rdi));
  task chk(input string n, input logic [31:0] g, e);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task acc(input logic i, w, input logic [7:0] o, input logic [3:0] b, input logic [31:0] d);
    @(posedge clock_i);
    sel <= 1'h1;
    io <= i;
    wr <= w;
    off <= o;
    be <= b;
    wd <= d;
    #1 ers = er;
    @(posedge clock_i);
    sel <= 1'h0;
    #1 rd = rdo;
  endtask
  task t_reset;
    chk("pins", {uco, sck, cs, dout, req, irq, pme}, 32'h0);
    acc(1'h0, 1'h0, 8'h00, 4'hF, 32'h0);
    chk("reset", rd & 32'hF7FFFFFF, 32'h10000002);
    acc(1'h0, 1'h0, 8'h08, 4'hF, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask
  task t_straps;
    mode <= 2'h1;
    vld <= 1'h0;
    repeat (3) @(posedge clock_i);
    acc(1'h0, 1'h0, 8'h00, 4'hF, 32'h0);
    chk("straps", rd & 32'h10000003, 32'h1);
    mode <= 2'h2;
    vld <= 1'h1;
  endtask
  task t_ctrl;
    // Reserved bits 23:8 written as zero, as software must
    acc(1'h0, 1'h1, 8'h00, 4'h1, 32'h000000FF);
    acc(1'h0, 1'h0, 8'h00, 4'hF, 32'h0);
    chk("ctrl", rd & 32'hF7FFFFFF, 32'h100000FE);
    uclk <= 1'h1;
    acc(1'h1, 1'h1, 8'h00, 4'h3, 32'h0);
    chk("io refused", {ers, uco}, 32'h3);
    acc(1'h1, 1'h1, 8'h00, 4'h1, 32'h0);
    chk("io byte", {ers, uco}, 32'h0);
  endtask
  task t_lane;
    for (int l = 0; l < 4; l++)
    begin
      acc(1'h0, 1'h1, 8'h00, 4'h1, 32'(l) << 3);
      chk("lane wr", nwd, 8'h11 * (l + 1));
      chk("lane rd", mrd, 32'hA5 << (8 * l));
    end
    @(posedge clock_i);
    b32 <= 1'h1;
    @(posedge clock_i);
    #1 chk("bus32", nwd, 8'h11);
  endtask
  task t_rom;
    acc(1'h0, 1'h1, 8'h00, 4'h8, 32'h02000000);
    for (int i = 0; i < 4; i++)
    begin
      repeat (3) @(posedge clock_i);
      acc(1'h0, 1'h0, 8'h00, 4'hF, 32'h0);
      chk("data in", rd[27], PAT[7 - i]);
      acc(1'h0, 1'h1, 8'h00, 4'h8, 32'h03000000 | (32'(i & 1) << 26));
      chk("sel clk dout", {cs, sck, dout}, 32'h6 | (i & 1));
      acc(1'h0, 1'h1, 8'h00, 4'h8, 32'h02000000);
    end
    acc(1'h0, 1'h1, 8'h00, 4'h8, 32'h20000000);
    chk("reload", {req, cs}, 32'h2);
    done <= 1'h1;
    @(posedge clock_i);
    done <= 1'h0;
    #1 chk("reload end", req, 1'h0);
  endtask
  task t_pd;
    for (int f = 0; f < 4; f++)
    begin
      acc(1'h0, 1'h1, 8'h00, 4'h1, 32'(f) << 5);
      pdr <= 1'h1;
      repeat (5) @(posedge clock_i);
      for (int k = 0; k < 4; k++)
      begin
        #1 chk("irq", irq, f != 0 && f <= k);
        repeat (10) @(posedge clock_i);
      end
      pdr <= 1'h0;
      repeat (3) @(posedge clock_i);
      #1 chk("irq off", irq, 1'h0);
    end
  endtask
  task t_pme;
    int n;
    for (int e = 1; e >= 0; e--)
    begin
      acc(1'h0, 1'h1, 8'h00, 4'h1, 32'(e) << 7);
      n = 0;
      mp2 <= 1'h1;
      repeat (6)
      begin
        @(posedge clock_i);
        #1 n += pme;
      end
      chk("wake", n, e);
      mp2 <= 1'h0;
      repeat (4) @(posedge clock_i);
    end
    // Inverted polarity makes the idle-low pin the active level
    acc(1'h0, 1'h1, 8'h00, 4'h1, 32'h00000080);
    n = 0;
    pol <= 1'h1;
    repeat (6)
    begin
      @(posedge clock_i);
      #1 n += pme;
    end
    chk("wake pol", n, 1);
    pol <= 1'h0;
    repeat (4) @(posedge clock_i);
  endtask
  task final_report;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clock_i);
    t_reset;
    t_ctrl;
    t_lane;
    t_rom;
    t_pd;
    t_pme;
    t_straps;
    final_report;
  end
  // Tests need well under 1000 cycles; this cuts off a hang
  initial
  begin
    #300000;
    error_cnt++;
    final_report;
  end
endmodule // lccr_top_tb
`default_nettype wire
